/* File: pfa_core.sv */
// Program flow, return stack and data addressing with APB access
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps

module pfa_core
   import pfa_pkg::*;
#(
   parameter int STACK_DEPTH = 8,
   parameter int PC_W        = 11
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic      [PC_W-1:0]   program_counter,
   output logic                   skip_active
);

   if (PC_W != 11 || STACK_DEPTH < 2) begin : g_chk
      $error("pfa_core: PC_W must be 11 and STACK_DEPTH at least 2");
   end

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [PC_W-1:0] pc_reg;
   logic [PC_W-1:0] stack_reg [STACK_DEPTH];
   logic [7:0]      status_reg;
   logic [7:0]      fsp_reg;
   logic [7:0]      w_reg;
   logic [7:0]      timer_reg;
   logic [7:0]      mem_addr_reg;
   logic [7:0]      dmem [256];
   pfa_skip_e       skip_reg;
   logic [31:0]     prdata_reg;
   logic            pready_reg;
   logic            pslverr_reg;
   logic            skip_out_reg;

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   wire logic apb_setup = psel & ~penable;
   wire logic apb_done  = psel & penable & pready_reg;
   wire logic a_issue   = (paddr == PFA_RA_ISSUE);
   wire logic a_flow    = (paddr == PFA_RA_FLOW);
   wire logic a_core    = (paddr == PFA_RA_CORE);
   wire logic a_maddr   = (paddr == PFA_RA_MEMADDR);
   wire logic a_mdata   = (paddr == PFA_RA_MEMDATA);
   wire logic a_mapped  = a_issue | a_flow | a_core | a_maddr | a_mdata;
   wire logic issue_fire = apb_done & pwrite & a_issue;
   wire logic mem_fire   = apb_done & pwrite & a_mdata;
   wire logic maddr_fire = apb_done & pwrite & a_maddr;

   ////////////////////////////////////////////////////////////////////////
   // Instruction fields
   wire logic [4:0] op  = pwdata[PFA_FLD_OP_LSB +: 5];
   wire logic [4:0] fr  = pwdata[PFA_FLD_FR_LSB +: 5];
   wire logic [2:0] bsel = pwdata[PFA_FLD_BIT_LSB +: 3];
   wire logic [7:0] lit = pwdata[PFA_FLD_LIT_LSB +: 8];
   wire logic [8:0] tgt = pwdata[PFA_FLD_LIT_LSB +: 9];
   wire logic [1:0] page_lo = status_reg[PFA_PAGE_LSB +: 2];

   // Squashed words still advance the counter and end the skip unless a prefix, but touch nothing else
   wire logic skipping = (skip_reg == PFA_SKIP_PEND);
   wire logic go       = issue_fire & ~skipping;
   wire logic squash   = issue_fire & skipping;
   wire logic is_pref  = (op == PFA_OP_PAGE) | (op == PFA_OP_BANK);

   wire logic op_inc  = go & (op == PFA_OP_INCSZ);
   wire logic op_dec  = go & (op == PFA_OP_DECSKZ);
   wire logic op_setb = go & (op == PFA_OP_SETB);
   wire logic op_bclr = go & (op == PFA_OP_BITCLR);
   wire logic op_skst = go & (op == PFA_OP_SKSET);
   wire logic op_skcl = go & (op == PFA_OP_SKCLR);
   wire logic op_mvwf = go & (op == PFA_OP_MOVWF);
   wire logic op_jump = go & (op == PFA_OP_JUMP);
   wire logic op_call = go & (op == PFA_OP_CALL);
   wire logic op_page = go & (op == PFA_OP_PAGE);
   wire logic op_bank = go & (op == PFA_OP_BANK);
   wire logic op_pgret = go & (op == PFA_OP_RETPAGE);
   wire logic op_tmret = go & (op == PFA_OP_RETINTADD);
   wire logic op_litret = go & (op == PFA_OP_RETLIT);
   wire logic op_pop  = go & ((op == PFA_OP_RETURN) |
                              (op == PFA_OP_RETPAGE) |
                              (op == PFA_OP_RETINT) |
                              (op == PFA_OP_RETINTADD) |
                              (op == PFA_OP_RETLIT));

   ////////////////////////////////////////////////////////////////////////
   // Effective data address
   wire logic [7:0] dir_addr =
      fr[4] ? {fsp_reg[7:PFA_BANK_LSB], fr}
            : {3'h0, fr};
   wire logic [7:0] eff_addr =
      (fr == 5'h00) ? fsp_reg : dir_addr;
   wire logic [7:0] acc_addr = a_issue ? eff_addr : mem_addr_reg;

   // Issue-word reads of the alias location see the pointed-to register instead; the memory window sees dmem[0]
   wire logic [7:0] rd_val =
      (acc_addr == PFA_DA_TIMER)  ? timer_reg :
      (acc_addr == PFA_DA_PCL)    ? pc_reg[7:0] :
      (acc_addr == PFA_DA_STATUS) ? status_reg :
      (acc_addr == PFA_DA_FSP)    ? fsp_reg :
                                    dmem[acc_addr];

   wire logic [7:0] inc_val = rd_val + 8'h01;
   wire logic [7:0] dec_val = rd_val - 8'h01;
   wire logic [7:0] bmask   = 8'h01 << bsel;
   wire logic       tbit    = rd_val[bsel];

   ////////////////////////////////////////////////////////////////////////
   // Single data write port
   wire logic wr_en = op_inc | op_dec | op_setb | op_bclr | op_mvwf |
                      mem_fire;
   wire logic [7:0] wr_data =
      mem_fire ? pwdata[7:0] :
      op_inc   ? inc_val :
      op_dec   ? dec_val :
      op_setb  ? (rd_val | bmask) :
      op_bclr  ? (rd_val & ~bmask) :
                 w_reg;
   wire logic wr_timer = wr_en & (acc_addr == PFA_DA_TIMER);
   wire logic wr_pcl  = wr_en & (acc_addr == PFA_DA_PCL);
   wire logic wr_stat = wr_en & (acc_addr == PFA_DA_STATUS);
   wire logic wr_fsp  = wr_en & (acc_addr == PFA_DA_FSP);
   wire logic wr_mem  = wr_en & (acc_addr > PFA_DA_FSP);

   ////////////////////////////////////////////////////////////////////////
   // Skip decisions
   wire logic skip_hit =
      (op_inc & (inc_val == 8'h00)) |
      (op_dec & (dec_val == 8'h00)) |
      (op_skst & tbit) |
      (op_skcl & ~tbit);

   ////////////////////////////////////////////////////////////////////////
   // Next values
   wire logic [PC_W-1:0] pc_inc = pc_reg + 11'h001;
   wire logic [PC_W-1:0] pc_next =
      op_jump ? {page_lo, tgt} :
      op_call ? {page_lo, 1'b0, lit} :
      op_pop  ? stack_reg[0] :
      wr_pcl  ? {pc_reg[10:8], wr_data} :
      issue_fire ? pc_inc : pc_reg;

   wire logic [7:0] status_next =
      wr_stat ? wr_data :
      op_page ? {lit[2:0], status_reg[4:0]} :
      op_pgret ? {status_reg[7], stack_reg[0][10:9],
                 status_reg[4:0]} :
                status_reg;

   wire logic [7:0] fsp_next =
      wr_fsp  ? wr_data :
      op_bank ? {lit[7:PFA_BANK_LSB], fsp_reg[4:0]} :
                fsp_reg;

   // Plain and interrupt returns leave the working register alone
   wire logic [7:0] w_next =
      (go & (op == PFA_OP_MOVLW)) ? lit :
      (go & (op == PFA_OP_MOVFW)) ? rd_val :
      op_litret ? lit :
                w_reg;

   // Counter wraps, carry dropped on purpose
   wire logic [7:0] timer_sum = 8'(timer_reg + w_reg);
   wire logic [7:0] timer_next =
      wr_timer ? wr_data :
      op_tmret ? timer_sum :
                 timer_reg;

   // A prefix keeps the skip alive so the jump after it goes too
   wire logic keep_skip = squash & is_pref;
   wire logic end_skip  = squash & ~is_pref;
   wire pfa_skip_e skip_next =
      skip_hit  ? PFA_SKIP_PEND :
      keep_skip ? PFA_SKIP_PEND :
      end_skip  ? PFA_SKIP_IDLE : skip_reg;

   ////////////////////////////////////////////////////////////////////////
   // Read mux
   wire logic [31:0] flow_word =
      {15'h0000, skipping, 5'h00, pc_reg};
   wire logic [31:0] core_word =
      {timer_reg, fsp_reg, status_reg, w_reg};
   wire logic [31:0] maddr_word = {24'h000000, mem_addr_reg};
   wire logic [31:0] mdata_word = {24'h000000, rd_val};
   wire logic [31:0] rd_mux =
      a_flow  ? flow_word :
      a_core  ? core_word :
      a_maddr ? maddr_word :
      a_mdata ? mdata_word : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // Return stack
   for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
      wire logic [PC_W-1:0] push_src = (i == 0) ? pc_inc
                                                : stack_reg[(i == 0) ? 0 : i-1];
      wire logic [PC_W-1:0] pop_src  = (i == STACK_DEPTH-1) ? stack_reg[i]
         : stack_reg[(i == STACK_DEPTH-1) ? i : i+1];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            stack_reg[i] <= '0;
         end else if (op_call) begin
            stack_reg[i] <= push_src;
         end else if (op_pop) begin
            stack_reg[i] <= pop_src;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core registers, one short process each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_reg <= PFA_PC_RST;
      end else begin
         pc_reg <= pc_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= PFA_STATUS_RST;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsp_reg <= PFA_FSP_RST;
      end else begin
         fsp_reg <= fsp_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_reg <= 8'h00;
      end else begin
         w_reg <= w_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_reg <= 8'h00;
      end else begin
         timer_reg <= timer_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_reg <= PFA_SKIP_IDLE;
      end else begin
         skip_reg <= skip_next;
      end
   end

   // Plain storage has no reset, like the array it models
   always_ff @(posedge pclk) begin
      if (wr_mem) begin
         dmem[acc_addr] <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave, one cycle access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr_reg <= 8'h00;
      end else if (maddr_fire) begin
         mem_addr_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= apb_setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= apb_setup & ~a_mapped;
      end
   end

   // Read data is taken at setup so it stands through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (apb_setup) begin
         prdata_reg <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_out_reg <= 1'b0;
      end else begin
         skip_out_reg <= (skip_next == PFA_SKIP_PEND);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output ports
   assign prdata          = prdata_reg;
   assign pready          = pready_reg;
   assign pslverr         = pslverr_reg;
   assign program_counter = pc_reg;
   assign skip_active     = skip_out_reg;

endmodule

/* File: pfa_core_asserts.sv */
// Checker for skip, flow and bus timing of pfa_core
`timescale 1ns/10ps
module pfa_core_asserts
   import pfa_pkg::*;
#(
   parameter int STACK_DEPTH = 8,
   parameter int PC_W        = 11
) (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [7:0]      paddr,
   input wire logic [31:0]     pwdata,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic [PC_W-1:0] program_counter,
   input wire logic            skip_active
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   wire logic       acc_wr   = psel && penable && pready && pwrite;
   wire logic       issue_go = acc_wr && paddr == PFA_RA_ISSUE;
   wire logic [4:0] op       = pwdata[4:0];
   wire logic       live     = issue_go && !skip_active;
   wire logic       sq       = issue_go && skip_active;
   wire logic       prefix   = op == PFA_OP_PAGE || op == PFA_OP_BANK;
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence live_s(logic [4:0] o);
      live && op == o;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_ready_one_cycle: assert property (setup_s |=> pready ##1 !pready)
      else $error("ready not a single cycle after setup");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_jump_target: assert property (
      live_s(PFA_OP_JUMP) |=> program_counter[8:0] == $past(pwdata[24:16]))
      else $error("jump target bits wrong");
   chk_call_target: assert property (
      live_s(PFA_OP_CALL) |=>
         program_counter[8:0] == {1'b0, $past(pwdata[23:16])})
      else $error("call target bits wrong");
   chk_nop_step: assert property (
      live_s(PFA_OP_NOP) |=>
         program_counter == $past(program_counter) + 1'b1 && !skip_active)
      else $error("plain issue did not step");
   chk_squash_step: assert property (
      sq |=> program_counter == $past(program_counter) + 1'b1)
      else $error("squashed word did more than step");
   chk_prefix_hold: assert property (sq && prefix |=> skip_active)
      else $error("skip ended on a prefix");
   chk_skip_end: assert property (sq && !prefix |=> !skip_active)
      else $error("skip not ended by ordinary word");
   chk_skip_stays: assert property (
      skip_active && !issue_go |=> skip_active)
      else $error("pending skip lost without issue");
   chk_pc_idle: assert property (
      !acc_wr |=> $stable(program_counter))
      else $error("counter moved without a write");
endmodule

bind pfa_core pfa_core_asserts #(.STACK_DEPTH(STACK_DEPTH), .PC_W(PC_W))
   u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .program_counter(program_counter),
   .skip_active(skip_active));

/* File: pfa_pkg.sv */
// Constants and types for the program flow and addressing block
package pfa_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Operation codes carried in the issue word
   localparam logic [4:0] PFA_OP_NOP   = 5'h00;
   localparam logic [4:0] PFA_OP_MOVLW = 5'h01;
   localparam logic [4:0] PFA_OP_MOVWF = 5'h02;
   localparam logic [4:0] PFA_OP_MOVFW = 5'h03;
   localparam logic [4:0] PFA_OP_INCSZ = 5'h04;
   localparam logic [4:0] PFA_OP_DECSKZ = 5'h05;
   localparam logic [4:0] PFA_OP_SETB  = 5'h06;
   localparam logic [4:0] PFA_OP_BITCLR = 5'h07;
   localparam logic [4:0] PFA_OP_SKSET = 5'h08;
   localparam logic [4:0] PFA_OP_SKCLR = 5'h09;
   localparam logic [4:0] PFA_OP_JUMP  = 5'h0A;
   localparam logic [4:0] PFA_OP_CALL  = 5'h0B;
   localparam logic [4:0] PFA_OP_PAGE  = 5'h0C;
   localparam logic [4:0] PFA_OP_BANK  = 5'h0D;
   localparam logic [4:0] PFA_OP_RETURN    = 5'h0E;
   localparam logic [4:0] PFA_OP_RETPAGE   = 5'h0F;
   localparam logic [4:0] PFA_OP_RETINT    = 5'h10;
   localparam logic [4:0] PFA_OP_RETINTADD = 5'h11;
   localparam logic [4:0] PFA_OP_RETLIT    = 5'h12;

   ////////////////////////////////////////////////////////////////////////
   // Issue word field positions
   localparam int PFA_FLD_OP_LSB  = 0;
   localparam int PFA_FLD_FR_LSB  = 8;
   localparam int PFA_FLD_BIT_LSB = 13;
   localparam int PFA_FLD_LIT_LSB = 16;

   ////////////////////////////////////////////////////////////////////////
   // Data memory map
   localparam logic [7:0] PFA_DA_ALIAS  = 8'h00;
   localparam logic [7:0] PFA_DA_TIMER  = 8'h01;
   localparam logic [7:0] PFA_DA_PCL    = 8'h02;
   localparam logic [7:0] PFA_DA_STATUS = 8'h03;
   localparam logic [7:0] PFA_DA_FSP    = 8'h04;
   localparam int         PFA_PAGE_LSB  = 5;
   localparam int         PFA_BANK_LSB  = 5;

   ////////////////////////////////////////////////////////////////////////
   // APB register offsets
   localparam logic [7:0] PFA_RA_ISSUE   = 8'h00;
   localparam logic [7:0] PFA_RA_FLOW    = 8'h04;
   localparam logic [7:0] PFA_RA_CORE    = 8'h08;
   localparam logic [7:0] PFA_RA_MEMADDR = 8'h0C;
   localparam logic [7:0] PFA_RA_MEMDATA = 8'h10;
   localparam int         PFA_FLOW_SKIP  = 16;

   ////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [10:0] PFA_PC_RST     = 11'h7FF;
   localparam logic [7:0]  PFA_STATUS_RST = 8'h18;
   localparam logic [7:0]  PFA_FSP_RST    = 8'h80;

   typedef enum logic [1:0] {
      PFA_SKIP_IDLE = 2'b01,
      PFA_SKIP_PEND = 2'b10
   } pfa_skip_e;

endpackage

/* File: tb.sv */
// Self-checking bench for pfa_core
`timescale 1ns/10ps
module tb;
   import pfa_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        skip_active, err_seen;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [10:0] program_counter;
   int          n_errors, checks_done, j;
   logic [10:0] exp_pc;
   pfa_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .program_counter(program_counter), .skip_active(skip_active));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Master holds everything until ready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16 && pready !== 1'b1; i++)
         @(posedge pclk);
      rv = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   task automatic iss(input logic [4:0] op, input logic [4:0] fr,
                      input logic [2:0] b, input logic [8:0] lit);
      apb(1'b1, PFA_RA_ISSUE, {7'h00, lit, b, fr, 3'h0, op});
   endtask
   task automatic mem(input logic [7:0] a);
      apb(1'b1, PFA_RA_MEMADDR, {24'h0, a});
      apb(1'b0, PFA_RA_MEMDATA, 32'h0);
   endtask
   task automatic flow_is(input logic [10:0] pc, input logic sk);
      apb(1'b0, PFA_RA_FLOW, 32'h0);
      chk("flow", {15'h0, sk, 5'h0, pc}, rv);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      flow_is(PFA_PC_RST, 1'b0);
      apb(1'b0, PFA_RA_CORE, 32'h0);
      chk("core", {8'h00, PFA_FSP_RST, PFA_STATUS_RST, 8'h00}, rv);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, {31'h0, err_seen});
      $display("t_reset done");
   endtask
   task automatic t_addr();
      iss(PFA_OP_MOVLW, 5'h00, 3'h0, 9'h025);
      iss(PFA_OP_MOVWF, 5'h04, 3'h0, 9'h000);
      iss(PFA_OP_MOVLW, 5'h00, 3'h0, 9'h05A);
      iss(PFA_OP_MOVWF, 5'h00, 3'h0, 9'h000);
      mem(8'h25);
      chk("indirect", 32'h5A, rv);
      iss(PFA_OP_BANK, 5'h00, 3'h0, 9'h0E0);
      apb(1'b0, PFA_RA_CORE, 32'h0);
      chk("pointer", 32'hE5, {24'h0, rv[23:16]});
      iss(PFA_OP_MOVWF, 5'h12, 3'h0, 9'h000);
      mem(8'hF2);
      chk("banked", 32'h5A, rv);
      $display("t_addr done");
   endtask
   task automatic t_bits();
      iss(PFA_OP_SETB, 5'h12, 3'h0, 9'h000);
      iss(PFA_OP_BITCLR, 5'h12, 3'h6, 9'h000);
      mem(8'hF2);
      chk("bits", 32'h1B, rv);
      iss(PFA_OP_SKCLR, 5'h12, 3'h2, 9'h000);
      flow_is(11'h008, 1'b1);
      iss(PFA_OP_MOVLW, 5'h00, 3'h0, 9'h077);
      apb(1'b0, PFA_RA_CORE, 32'h0);
      chk("w kept", 32'h5A, {24'h0, rv[7:0]});
      iss(PFA_OP_SKSET, 5'h12, 3'h2, 9'h000);
      flow_is(11'h00A, 1'b0);
      $display("t_bits done");
   endtask
   task automatic t_incdec();
      iss(PFA_OP_MOVLW, 5'h00, 3'h0, 9'h0FF);
      iss(PFA_OP_MOVWF, 5'h12, 3'h0, 9'h000);
      iss(PFA_OP_INCSZ, 5'h12, 3'h0, 9'h000);
      flow_is(11'h00D, 1'b1);
      iss(PFA_OP_NOP, 5'h00, 3'h0, 9'h000);
      iss(PFA_OP_DECSKZ, 5'h12, 3'h0, 9'h000);
      flow_is(11'h00F, 1'b0);
      mem(8'hF2);
      chk("dec value", 32'hFF, rv);
      $display("t_incdec done");
   endtask
   task automatic t_prefix();
      iss(PFA_OP_SKSET, 5'h12, 3'h7, 9'h000);
      iss(PFA_OP_PAGE, 5'h00, 3'h0, 9'h003);
      iss(PFA_OP_BANK, 5'h00, 3'h0, 9'h000);
      iss(PFA_OP_JUMP, 5'h00, 3'h0, 9'h100);
      flow_is(11'h013, 1'b0);
      apb(1'b0, PFA_RA_CORE, 32'h0);
      chk("untouched", 32'hE518, {16'h0, rv[23:8]});
      iss(PFA_OP_PAGE, 5'h00, 3'h0, 9'h005);
      iss(PFA_OP_JUMP, 5'h00, 3'h0, 9'h1AB);
      flow_is(11'h3AB, 1'b0);
      iss(PFA_OP_SETB, 5'h03, 3'h6, 9'h000);
      apb(1'b0, PFA_RA_CORE, 32'h0);
      chk("status", 32'hF8, {24'h0, rv[15:8]});
      $display("t_prefix done");
   endtask
   // Nine calls overflow eight levels; the oldest return is lost
   task automatic t_stack();
      iss(PFA_OP_PAGE, 5'h00, 3'h0, 9'h000);
      iss(PFA_OP_JUMP, 5'h00, 3'h0, 9'h000);
      for (j = 1; j <= 9; j++)
         iss(PFA_OP_CALL, 5'h00, 3'h0, 9'(j * 16));
      flow_is(11'h090, 1'b0);
      for (j = 1; j <= 10; j++) begin
         iss(PFA_OP_RETURN, 5'h00, 3'h0, 9'h000);
         exp_pc = (j <= 8) ? 11'((9 - j) * 16 + 1) : 11'h011;
         flow_is(exp_pc, 1'b0);
      end
      $display("t_stack done");
   endtask
   task automatic t_ret();
      iss(PFA_OP_PAGE, 5'h00, 3'h0, 9'h002);
      iss(PFA_OP_CALL, 5'h00, 3'h0, 9'h077);
      flow_is(11'h477, 1'b0);
      iss(PFA_OP_RETPAGE, 5'h00, 3'h0, 9'h000);
      apb(1'b0, PFA_RA_CORE, 32'h0);
      chk("paged", 32'h18, {24'h0, rv[15:8]});
      iss(PFA_OP_MOVLW, 5'h00, 3'h0, 9'h021);
      iss(PFA_OP_CALL, 5'h00, 3'h0, 9'h030);
      iss(PFA_OP_RETURN, 5'h00, 3'h0, 9'h000);
      apb(1'b0, PFA_RA_CORE, 32'h0);
      chk("w plain", 32'h21, {24'h0, rv[7:0]});
      iss(PFA_OP_CALL, 5'h00, 3'h0, 9'h030);
      iss(PFA_OP_RETLIT, 5'h00, 3'h0, 9'h03C);
      iss(PFA_OP_CALL, 5'h00, 3'h0, 9'h030);
      iss(PFA_OP_RETINTADD, 5'h00, 3'h0, 9'h000);
      iss(PFA_OP_CALL, 5'h00, 3'h0, 9'h030);
      iss(PFA_OP_RETINT, 5'h00, 3'h0, 9'h000);
      flow_is(11'h018, 1'b0);
      apb(1'b0, PFA_RA_CORE, 32'h0);
      chk("core", 32'h3CE5183C, rv);
      $display("t_ret done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_errors = 0;
      checks_done = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_addr();
      t_bits();
      t_incdec();
      t_prefix();
      t_stack();
      t_ret();
      tally_and_finish();
   end
endmodule
